/* File: rtl/rsp_pkg.sv */
// package: constants, codes and types of the rs485 slave serial port
// Summary of operation
// [RQ1] command source code: 02 panel, 03 serial, 04 card one, 05 card two
// [RQ2] bit rate code: 02 test, 03 2400, 04 4800, 05 9600, 06 19200; default 04
// [RQ3] node address 1 to 32, default 1; only matching messages are ours
// [RQ4] data length code 07 gives seven bits, 08 eight; default seven
// [RQ5] parity code 00 none, 01 even, 02 odd; default none
// [RQ6] stop bit code 01 one stop bit, 02 two; default one
// [RQ7] reply start delayed by wait time 0.0 to 1000 ms, default zero
// [RQ8] every node is a slave; only the master starts exchanges; max 32 nodes
// [RQ9] master and slaves share line settings; each node has a distinct address
// [RQ10] wait counted from final stop bit; driver enabled only after it expires
`default_nettype none
package rsp_pkg;
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int OVS           = 16;
  localparam int DIVW          = 12;
  localparam int APB_AW        = 8;

  // oversample divisors, one tick is a sixteenth of a bit
  localparam logic [DIVW-1:0] DIV_TEST = 12'h001;
  localparam logic [DIVW-1:0] DIV_2400 = DIVW'(CLK_HZ / (2400 * OVS));
  localparam logic [DIVW-1:0] DIV_4800 = DIVW'(CLK_HZ / (4800 * OVS));
  localparam logic [DIVW-1:0] DIV_9600 = DIVW'(CLK_HZ / (9600 * OVS));
  localparam logic [DIVW-1:0] DIV_19200 = DIVW'(CLK_HZ / (19200 * OVS));
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST7 = 3'h6;
  localparam logic [2:0] BIT_LAST8 = 3'h7;

  // setting codes
  localparam logic [7:0] SRC_PANEL  = 8'h02;
  localparam logic [7:0] SRC_SERIAL = 8'h03;
  localparam logic [7:0] SRC_CARD1  = 8'h04;
  localparam logic [7:0] SRC_CARD2  = 8'h05;
  localparam logic [7:0] RATE_TEST  = 8'h02;
  localparam logic [7:0] RATE_2400  = 8'h03;
  localparam logic [7:0] RATE_4800  = 8'h04;
  localparam logic [7:0] RATE_9600  = 8'h05;
  localparam logic [7:0] RATE_19200 = 8'h06;
  localparam logic [7:0] ADDR_MIN   = 8'h01;
  localparam logic [7:0] ADDR_MAX   = 8'h20;
  localparam logic [7:0] LEN_7      = 8'h07;
  localparam logic [7:0] LEN_8      = 8'h08;
  localparam logic [7:0] PAR_NONE   = 8'h00;
  localparam logic [7:0] PAR_EVEN   = 8'h01;
  localparam logic [7:0] PAR_ODD    = 8'h02;
  localparam logic [7:0] STOP_1     = 8'h01;
  localparam logic [7:0] STOP_2     = 8'h02;

  // wait time in units of 0.1 ms
  localparam int WAIT_W        = 14;
  localparam int PREW          = 12;
  localparam int WAIT_UNIT_NS  = 100_000;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [PREW-1:0] WAIT_UNIT_LAST = PREW'(WAIT_UNIT_CYC - 1);
  localparam logic [WAIT_W-1:0] WAIT_MAX = 14'h2710;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 14'h0000;

  // idle line for 22 bit times marks a message boundary
  localparam logic [8:0] GAP_TICKS = 9'h160;

  // register offsets
  localparam logic [APB_AW-1:0] REG_CMD_SRC = 8'h00;
  localparam logic [APB_AW-1:0] REG_RATE    = 8'h04;
  localparam logic [APB_AW-1:0] REG_ADDR    = 8'h08;
  localparam logic [APB_AW-1:0] REG_LEN     = 8'h0C;
  localparam logic [APB_AW-1:0] REG_PARITY  = 8'h10;
  localparam logic [APB_AW-1:0] REG_STOP    = 8'h14;
  localparam logic [APB_AW-1:0] REG_WAIT    = 8'h18;
  localparam logic [APB_AW-1:0] REG_STATUS  = 8'h1C;
  localparam logic [APB_AW-1:0] REG_RXDATA  = 8'h20;
  localparam logic [APB_AW-1:0] REG_TXDATA  = 8'h24;

  typedef struct packed {
    logic [7:0]        src;
    logic [7:0]        rate;
    logic [7:0]        addr;
    logic [7:0]        len;
    logic [7:0]        par;
    logic [7:0]        stop;
    logic [WAIT_W-1:0] wait_units;
  } rsp_cfg_t;

  localparam rsp_cfg_t CFG_RESET = '{src: SRC_PANEL, rate: RATE_4800,
    addr: ADDR_MIN, len: LEN_7, par: PAR_NONE, stop: STOP_1,
    wait_units: WAIT_RESET};

  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
  } rsp_char_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_PAR   = 3'b011,
    ST_STOP  = 3'b100
  } rsp_bit_t;

  function automatic logic [DIVW-1:0] rsp_rate_div(input logic [7:0] code);
    case (code)
      RATE_TEST:  rsp_rate_div = DIV_TEST;
      RATE_2400:  rsp_rate_div = DIV_2400;
      RATE_9600:  rsp_rate_div = DIV_9600;
      RATE_19200: rsp_rate_div = DIV_19200;
      default:    rsp_rate_div = DIV_4800;
    endcase
  endfunction

  // parity over seven or eight data bits
  function automatic logic rsp_par_bit(input logic [7:0] d,
                                       input rsp_cfg_t c);
    logic p;
    p = (c.len == LEN_8) ? ^d : ^d[6:0];
    rsp_par_bit = (c.par == PAR_ODD) ? ~p : p;
  endfunction
endpackage
`default_nettype wire

/* File: rtl/rsp_rx.sv */
// character receiver with sixteen-fold oversampling
`timescale 1ns/10ps
`default_nettype none
module rsp_rx
  import rsp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick,
  input  wire logic              rxd,
  input  wire rsp_pkg::rsp_cfg_t cfg,
  output logic                   busy,
  output logic                   done,
  output rsp_pkg::rsp_char_t     rx_char
);
  rsp_bit_t   state, next_state;
  logic [3:0] ph, next_ph;
  logic [2:0] bitn, next_bitn;
  rsp_char_t  next_ch;
  logic       next_done;
  logic [2:0] last_bit;

  assign last_bit = (cfg.len == LEN_8) ? BIT_LAST8 : BIT_LAST7; // see RQ4
  assign busy = (state != ST_IDLE);

  // framing sequence, bits sampled at mid cell
  always_comb
  begin
    next_state = state;
    next_ph    = ph;
    next_bitn  = bitn;
    next_ch    = rx_char;
    next_done  = 1'b0;
    if (tick)
    begin
      next_ph = ph + 4'h1;
      case (state)
        ST_IDLE:
        begin
          next_ph = 4'h0;
          if (!rxd)
            next_state = ST_START;
        end
        ST_START:
          if (ph == OVS_HALF)
          begin
            // a glitch shorter than half a bit is not a start
            next_ph    = 4'h0;
            next_bitn  = 3'h0;
            next_ch    = '0;
            next_state = rxd ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (ph == OVS_LAST)
          begin
            next_ch.data[bitn] = rxd;
            next_bitn = bitn + 3'h1;
            if (bitn == last_bit)
            begin
              next_bitn  = 3'h0;
              next_state = (cfg.par == PAR_NONE) ? ST_STOP : ST_PAR; // see RQ5
            end
          end
        ST_PAR:
          if (ph == OVS_LAST)
          begin
            next_ch.par_err = (rxd != rsp_par_bit(rx_char.data, cfg)); // see RQ5
            next_state = ST_STOP;
          end
        ST_STOP:
          if (ph == OVS_LAST)
          begin
            if (!rxd)
              next_ch.frm_err = 1'b1;
            if (cfg.stop == STOP_2 && bitn == 3'h0) // see RQ6
              next_bitn = 3'h1;
            else
            begin
              next_done  = 1'b1;
              next_state = ST_IDLE;
            end
          end
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= ST_IDLE;
      ph      <= 4'h0;
      bitn    <= 3'h0;
      rx_char <= '0;
      done    <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      ph      <= next_ph;
      bitn    <= next_bitn;
      rx_char <= next_ch;
      done    <= next_done;
    end
  end
endmodule // rsp_rx
`default_nettype wire

/* File: rtl/rsp_top.sv */
// rs485 slave serial port: apb registers, receiver, reply timer, sender
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rsp_top
  import rsp_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd_pin,
  output logic                   txd_pin,
  output logic                   tx_drive_en,
  output logic      [7:0]        cmd_source
);
  rsp_cfg_t          cfg, next_cfg;
  logic              rxd_meta, rxd_s;
  logic [DIVW-1:0]   div_cnt, next_div_cnt;
  logic              tick, next_tick;
  logic              rx_busy, rx_done, rx_ok;
  rsp_char_t         rx_char;
  logic              next_pready, next_pslverr;
  logic [31:0]       next_prdata, rd_mux;
  logic              access, wr_en, pop;
  logic              rxv, ovr, tx_pend, next_rxv, next_ovr, next_tx_pend;
  rsp_char_t         rx_hold, next_rx_hold;
  logic [7:0]        tx_byte, next_tx_byte;
  logic [8:0]        idle_cnt, next_idle_cnt;
  logic              at_gap, own, next_at_gap, next_own, accept, match;
  logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
  logic [PREW-1:0]   pre_cnt, next_pre_cnt;
  logic              reply_ok, tx_go, tx_on;
  rsp_bit_t          tx_state, next_tx_state;
  logic [3:0]        tx_ph, next_tx_ph;
  logic [2:0]        tx_bitn, next_tx_bitn;
  logic [7:0]        tx_sh, next_tx_sh;
  logic              next_txd, next_tx_en;
  logic [2:0]        tx_last;

  assign cmd_source = cfg.src; // see RQ1

  // two-stage synchroniser for the line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd_pin;
      rxd_s    <= rxd_meta;
    end
  end

  // oversample tick; restarts at once when the divisor shrinks
  always_comb
  begin
    next_div_cnt = div_cnt + 12'h001;
    next_tick    = 1'b0;
    if (div_cnt >= rsp_rate_div(cfg.rate) - 12'h001) // see RQ2
    begin
      next_div_cnt = 12'h000;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 12'h000;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  rsp_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .rxd     (rxd_s),
    .cfg     (cfg),
    .busy    (rx_busy),
    .done    (rx_done),
    .rx_char (rx_char)
  );

  // own echo while sending is not a received character
  assign rx_ok    = rx_done & ~tx_on;
  assign match    = (rx_char.data == cfg.addr);
  assign accept   = rx_ok & (at_gap ? match : own); // see RQ3
  assign access   = psel & penable;
  assign wr_en    = access & pready & pwrite;
  assign pop      = access & pready & ~pwrite & (paddr == REG_RXDATA);

  // read data mux, reserved bits read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CMD_SRC: rd_mux[7:0] = cfg.src;
      REG_RATE:    rd_mux[7:0] = cfg.rate;
      REG_ADDR:    rd_mux[7:0] = cfg.addr;
      REG_LEN:     rd_mux[7:0] = cfg.len;
      REG_PARITY:  rd_mux[7:0] = cfg.par;
      REG_STOP:    rd_mux[7:0] = cfg.stop;
      REG_WAIT:    rd_mux[WAIT_W-1:0] = cfg.wait_units;
      REG_STATUS:  rd_mux[6:0] = {wait_cnt != WAIT_RESET, tx_pend | tx_on,
                                  ovr, rx_hold.frm_err, rx_hold.par_err,
                                  own, rxv};
      REG_RXDATA:  rd_mux[7:0] = rx_hold.data;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // apb slave: answer one cycle into access, write at the pready edge
  always_comb
  begin
    next_cfg     = cfg;
    next_pready  = 1'b0;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    next_tx_byte = tx_byte;
    next_tx_pend = (tx_pend & ~tx_go);
    next_rxv     = (rxv & ~pop) | accept;
    next_ovr     = (ovr & ~pop) | (accept & rxv & ~pop);
    next_rx_hold = accept ? rx_char : rx_hold;
    if (access && !pready)
    begin
      next_pready  = 1'b1;
      next_prdata  = rd_mux;
      next_pslverr = (paddr > REG_TXDATA) || (paddr[1:0] != 2'b00);
    end
    if (wr_en)
      case (paddr)
        REG_CMD_SRC:
          if (pwdata[7:0] >= SRC_PANEL && pwdata[7:0] <= SRC_CARD2) // see RQ1
            next_cfg.src = pwdata[7:0];
        REG_RATE:
          if (pwdata[7:0] >= RATE_TEST && pwdata[7:0] <= RATE_19200) // see RQ2
            next_cfg.rate = pwdata[7:0];
        REG_ADDR:
          if (pwdata[7:0] >= ADDR_MIN && pwdata[7:0] <= ADDR_MAX) // see RQ3
            next_cfg.addr = pwdata[7:0];
        REG_LEN:
          if (pwdata[7:0] == LEN_7 || pwdata[7:0] == LEN_8) // see RQ4
            next_cfg.len = pwdata[7:0];
        REG_PARITY:
          if (pwdata[7:0] <= PAR_ODD) // see RQ5
            next_cfg.par = pwdata[7:0];
        REG_STOP:
          if (pwdata[7:0] == STOP_1 || pwdata[7:0] == STOP_2) // see RQ6
            next_cfg.stop = pwdata[7:0];
        REG_WAIT:
          if (pwdata[WAIT_W-1:0] <= WAIT_MAX && pwdata[31:WAIT_W] == '0)
            next_cfg.wait_units = pwdata[WAIT_W-1:0]; // see RQ7
        REG_TXDATA:
        begin
          // a new write wins over the start that empties the holding
          next_tx_byte = pwdata[7:0];
          next_tx_pend = 1'b1;
        end
        default:
          next_cfg = cfg;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg     <= CFG_RESET;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      tx_byte <= 8'h00;
      tx_pend <= 1'b0;
      rxv     <= 1'b0;
      ovr     <= 1'b0;
      rx_hold <= '0;
    end
    else
    begin
      cfg     <= next_cfg;
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
      tx_byte <= next_tx_byte;
      tx_pend <= next_tx_pend;
      rxv     <= next_rxv;
      ovr     <= next_ovr;
      rx_hold <= next_rx_hold;
    end
  end

  // message boundary, address match and reply wait timer
  always_comb
  begin
    next_idle_cnt = idle_cnt;
    next_at_gap   = at_gap;
    next_own      = own;
    next_wait_cnt = wait_cnt;
    next_pre_cnt  = pre_cnt;
    if (rx_busy || !rxd_s)
      next_idle_cnt = 9'h000;
    else if (tick && !at_gap)
      next_idle_cnt = idle_cnt + 9'h001;
    if (idle_cnt == GAP_TICKS)
      next_at_gap = 1'b1;
    if (rx_ok)
    begin
      if (at_gap)
        next_own = match; // see RQ3
      next_at_gap   = 1'b0;
      // each received character's final stop bit restarts the wait, so it runs from the last one
      next_wait_cnt = cfg.wait_units; // see RQ7
      next_pre_cnt  = '0;
    end
    else if (wait_cnt != WAIT_RESET)
    begin
      next_pre_cnt = pre_cnt + 12'h001;
      if (pre_cnt == WAIT_UNIT_LAST)
      begin
        next_pre_cnt  = '0;
        next_wait_cnt = wait_cnt - 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cnt <= 9'h000;
      at_gap   <= 1'b0;
      own      <= 1'b0;
      wait_cnt <= WAIT_RESET;
      pre_cnt  <= '0;
    end
    else
    begin
      idle_cnt <= next_idle_cnt;
      at_gap   <= next_at_gap;
      own      <= next_own;
      wait_cnt <= next_wait_cnt;
      pre_cnt  <= next_pre_cnt;
    end
  end

  // only answers an addressed message, after the wait, with the line quiet;
  // a stop bit seen this cycle reloads the wait, so it blocks a start too
  assign reply_ok = own & (wait_cnt == WAIT_RESET) & ~rx_busy
                  & ~rx_ok; // see RQ8
  assign tx_on    = (tx_state != ST_IDLE);
  assign tx_go    = ~tx_on & tx_pend & reply_ok; // see RQ10
  assign tx_last  = (cfg.len == LEN_8) ? BIT_LAST8 : BIT_LAST7;

  // sender; driver enabled for exactly the frame
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_ph    = tx_ph;
    next_tx_bitn  = tx_bitn;
    next_tx_sh    = tx_sh;
    next_txd      = txd_pin;
    next_tx_en    = tx_drive_en;
    if (tx_go)
    begin
      next_tx_state = ST_START;
      next_tx_ph    = 4'h0;
      next_tx_sh    = tx_byte;
      next_txd      = 1'b0;
      next_tx_en    = 1'b1; // see RQ10
    end
    else if (tick && tx_on)
    begin
      next_tx_ph = tx_ph + 4'h1;
      if (tx_ph == OVS_LAST)
        case (tx_state)
          ST_START:
          begin
            next_tx_state = ST_DATA;
            next_tx_bitn  = 3'h0;
            next_txd      = tx_sh[0];
          end
          ST_DATA:
            if (tx_bitn == tx_last) // see RQ4
            begin
              next_tx_bitn = 3'h0;
              if (cfg.par == PAR_NONE)
              begin
                next_tx_state = ST_STOP;
                next_txd      = 1'b1;
              end
              else
              begin
                next_tx_state = ST_PAR;
                next_txd      = rsp_par_bit(tx_sh, cfg); // see RQ5
              end
            end
            else
            begin
              next_tx_bitn = tx_bitn + 3'h1;
              next_txd     = tx_sh[tx_bitn + 3'h1];
            end
          ST_PAR:
          begin
            next_tx_state = ST_STOP;
            next_txd      = 1'b1;
          end
          ST_STOP:
            if (cfg.stop == STOP_2 && tx_bitn == 3'h0) // see RQ6
              next_tx_bitn = 3'h1;
            else
            begin
              next_tx_state = ST_IDLE;
              next_tx_en    = 1'b0;
            end
          default:
            next_tx_state = ST_IDLE;
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state    <= ST_IDLE;
      tx_ph       <= 4'h0;
      tx_bitn     <= 3'h0;
      tx_sh       <= 8'h00;
      txd_pin     <= 1'b1;
      tx_drive_en <= 1'b0;
    end
    else
    begin
      tx_state    <= next_tx_state;
      tx_ph       <= next_tx_ph;
      tx_bitn     <= next_tx_bitn;
      tx_sh       <= next_tx_sh;
      txd_pin     <= next_txd;
      tx_drive_en <= next_tx_en;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_match;
    rx_ok && at_gap && match;
  endsequence
  sequence s_first_other;
    rx_ok && at_gap && !match;
  endsequence

  AST_OWN_SET: assert property (s_first_match |=> own) // see RQ3
    else $error("addressed message not taken as own");
  AST_OWN_CLR: assert property (s_first_other |=> !own) // see RQ3
    else $error("foreign message taken as own");
  AST_SRC_LEGAL: assert property (cmd_source >= SRC_PANEL // see RQ1
    && cmd_source <= SRC_CARD2) else $error("bad command source");
  AST_ADDR_RANGE: assert property (cfg.addr >= ADDR_MIN // see RQ3
    && cfg.addr <= ADDR_MAX) else $error("node address out of range");
  AST_DIV_RANGE: assert property ($stable(cfg.rate) // see RQ2
    |-> div_cnt < rsp_rate_div(cfg.rate)) else $error("divider overrun");
  AST_LEN_LEGAL: assert property (cfg.len == LEN_7 // see RQ4
    || cfg.len == LEN_8) else $error("bad data length");
  AST_PAR_LEGAL: assert property (cfg.par <= PAR_ODD) // see RQ5
    else $error("bad parity code");
  AST_STOP_HIGH: assert property (tx_state == ST_STOP // see RQ6
    |-> txd_pin && tx_drive_en) else $error("stop bit not high");
  AST_WAIT_LOAD: assert property (rx_ok // see RQ7
    |=> wait_cnt == $past(cfg.wait_units)) else $error("wait not loaded");
  AST_DRIVE_AFTER_WAIT: assert property ($rose(tx_drive_en) // see RQ10
    |-> $past(wait_cnt) == WAIT_RESET && $past(own) && !txd_pin)
    else $error("driver enabled before wait expired");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
endmodule // rsp_top
`default_nettype wire

/* File: test/rsp_master_model.sv */
// master on the shared line: sends polls, samples replies
`timescale 1ns/10ps
`default_nettype none
module rsp_master_model
(
  input  wire logic pclk,
  input  wire logic line,
  output var logic  m_drv,
  output var logic  m_en
);
  int bit_clk = 16;
  int l8;
  int par;
  int st2;

  // idle before the first edge
  initial
  begin
    m_drv = 1'b1;
    m_en  = 1'b0;
  end

  // bits of one char, lsb first, with the slave's own settings
  function automatic logic [11:0] frame(input logic [7:0] d, output int n);
    logic p;
    p = (l8 != 0) ? ^d : ^d[6:0];
    frame = 12'hFFF;
    frame[0] = 1'b0;
    n = 1;
    for (int i = 0; i < 7 + l8; i++)
    begin
      frame[n] = d[i];
      n++;
    end
    if (par != 0)
    begin
      frame[n] = (par == 2) ? ~p : p;
      n++;
    end
    n = n + 1 + st2;
  endfunction

  // a poll after a long idle gap; only the master opens one
  task automatic send(input logic [7:0] d);
    logic [11:0] f;
    int          n;
    f = frame(d, n);
    repeat (30 * bit_clk) @(posedge pclk);
    m_en <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      m_drv <= f[i];
      repeat (bit_clk) @(posedge pclk);
    end
    m_en <= 1'b0;
  endtask

  // mid-bit sampling; a missing reply leaves all ones
  task automatic recv(input int n, output logic [11:0] f);
    int k;
    f = 12'hFFF;
    k = 0;
    while (line !== 1'b0 && k < 8000)
    begin
      @(posedge pclk);
      k++;
    end
    repeat (bit_clk / 2) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = line;
      repeat (bit_clk) @(posedge pclk);
    end
  endtask
endmodule // rsp_master_model
`default_nettype wire

/* File: test/rs485_slave_serial_port_tb.sv */
// bench for the rs485 slave serial port: apb setup, polls, replies
`timescale 1ns/10ps
`default_nettype none
module rs485_slave_serial_port_tb;
  import rsp_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              er;
  logic              txd_pin;
  logic              tx_drive_en;
  logic [7:0]        cmd_source;
  logic              m_drv;
  logic              m_en;
  wire               line;
  logic [31:0]       seed = 32'hAC6BC330;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  int                drv_cyc = 0;

  // bias resistors pull the released line high
  assign line = tx_drive_en ? txd_pin : (m_en ? m_drv : 1'b1);

  rsp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_pin(line),
    .txd_pin(txd_pin), .tx_drive_en(tx_drive_en),
    .cmd_source(cmd_source));
  rsp_master_model i_master (.pclk(pclk), .line(line), .m_drv(m_drv),
    .m_en(m_en));

  // clock and a count of driven cycles
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (tx_drive_en === 1'b1) drv_cyc++;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input int wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb_answer", 1, 32'(pready));
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int          e[7];
    logic [11:0] f;
    logic [11:0] fe;
    int          n;
    int          wt;
    int          ad;
    int          k;
    e = '{2, 4, 1, 7, 0, 1, 0};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("cmd_source", 2, 32'(cmd_source));
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'(4 * i), 0);
      chk("reset_value", e[i], rd);
    end
    apb(1'b0, 8'h28, 0);
    chk("unmapped_err", 1, 32'(er));
    apb(1'b1, REG_ADDR, 33);
    apb(1'b0, REG_ADDR, 0);
    chk("addr_range", 1, rd);
    for (int s = 2; s <= 7; s++)
    begin
      apb(1'b1, REG_CMD_SRC, s);
      apb(1'b1, REG_RATE, s);
      apb(1'b0, REG_RATE, 0);
      chk("cmd_source", (s > 5) ? 5 : s, 32'(cmd_source));
      chk("rate_code", (s > 6) ? 6 : s, rd);
    end
    apb(1'b1, REG_RATE, 2);
    // polls with every length, parity and stop setting
    for (int t = 0; t < 6; t++)
    begin
      seed = lfsr(seed);
      i_master.l8 = t % 2;
      i_master.par = t % 3;
      i_master.st2 = (t / 2) % 2;
      wt = int'(seed[5:4]) % 3;
      ad = (t == 5) ? 32 : (t == 4) ? 1 : int'(seed[10:6]) + 1;
      apb(1'b1, REG_LEN, 7 + i_master.l8);
      apb(1'b1, REG_PARITY, i_master.par);
      apb(1'b1, REG_STOP, 1 + i_master.st2);
      apb(1'b1, REG_WAIT, wt);
      apb(1'b1, REG_ADDR, ad);
      k = drv_cyc;
      i_master.send(8'(ad % 32 + 1));
      apb(1'b1, REG_TXDATA, int'(seed[19:12]));
      repeat (600) @(posedge pclk);
      chk("quiet_foreign", k, drv_cyc);
      i_master.send(8'(ad));
      k = 0;
      while (tx_drive_en !== 1'b1 && k < 6000)
      begin
        @(posedge pclk);
        k++;
      end
      // counted from the end of the poll's last stop bit
      chk("reply_delay", 1, 32'(k + 16 >= wt * WAIT_UNIT_CYC &&
        k <= wt * WAIT_UNIT_CYC + 40));
      fe = i_master.frame(seed[19:12], n);
      i_master.recv(n, f);
      chk("reply_frame", 32'(fe), 32'(f));
      repeat (16) @(posedge pclk);
      chk("driver_off", 0, 32'(tx_drive_en));
      apb(1'b0, REG_STATUS, 0);
      chk("own_flag", 1, 32'(rd[1]));
      chk("status", 32'h0000_0003, rd);
      apb(1'b0, REG_RXDATA, 0);
      chk("rx_data", ad, rd);
    end
    print_verdict();
  end

  // watchdog well beyond the longest expected run
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
endmodule // rs485_slave_serial_port_tb
`default_nettype wire
